// File: rpms_map.vh
`ifndef RPMS_MAP_VH
`define RPMS_MAP_VH
// Clock rate and time bases.
`define RPMS_CLK_HZ 125000000
`define RPMS_CYC_PER_MS (`RPMS_CLK_HZ / 1000)
// Least wake pulse high time in ns, and its cycle count rounded up.
`define RPMS_WAKE_MIN_NS 90000
`define RPMS_WAKE_MIN_CYC ((`RPMS_WAKE_MIN_NS + 7) / 8)
// Time mark pulse width in ms.
`define RPMS_MARK_MS 200
// Duty mode times.
`define RPMS_ADM_ON_MS 16'h01F4
`define RPMS_ADM_PERIOD_S 1
`define RPMS_EPH_PERIOD_S 1800
`define RPMS_EPH_ON_S 18
`define RPMS_EPH_ON_MS 16'h4650
`define RPMS_CAL_ON_MS 16'h00FA
`define RPMS_PFM_MIN_S 10
`define RPMS_PFM_MAX_S 7200
// Power mode codes.
`define RPMS_MODE_FULL 3'h0
`define RPMS_MODE_ADM 3'h1
`define RPMS_MODE_PFM 3'h2
`define RPMS_MODE_MPM 3'h3
// Host port kinds from straps.
`define RPMS_PORT_SPI 2'h0
`define RPMS_PORT_UART 2'h1
`define RPMS_PORT_I2C 2'h2
// Factory serial settings.
`define RPMS_BAUD_DEF 20'h012C0
`define RPMS_RATE_BIT 2
// Message kinds in the default schedule.
`define RPMS_MSG_FIX 2'h0
`define RPMS_MSG_DOP 2'h1
`define RPMS_MSG_REC 2'h2
`define RPMS_MSG_SAT 2'h3
`define RPMS_SAT_PERIOD 3'h5
`endif

// File: rpms_fifo.v
`timescale 1ns/10ps
`include "rpms_map.vh"
// Small flip-flop FIFO for the scheduled message stream.
module rpms_fifo #(
   parameter WIDTH = 4,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire core_clk,
   input wire reset_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_r;
   reg [AW-1:0] rd_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   // Full and empty come straight from the fill count.
   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers wrap naturally since the depth is a power of two.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         wr_r <= {AW{1'b0}};
         rd_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_r[wr_r] <= in_data;
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// File: rpms_sequencer.v
`timescale 1ns/10ps
`include "rpms_map.vh"
// Summary of operation
// - Power-up settles in hibernate, not navigation.
// - Host pulse wakes; first wake cold starts.
// - Supply loss restores factory settings, cold start.
// - Auto wake output looped back wakes device.
// - Mode bit two selects five fixes per second.
// - Port type latched at reset release only.
// - Straps open select SPI; resistors pick others.
// - UART framing 8N1, default 4800 baud.
// - Time mark 200 ms high at second.
// - Default schedule GGA GSA RMC, GSV fifth.
// - Ready message with each wake and each sleep.
// - Adaptive mode short on, hibernate between fixes.
// - Adaptive mode stays on for ephemeris, weak signal.
// - Periodic fix wakes each programmed period.
// - Periodic fix host pulse gives hot start.
// - Micro mode wakes 18 s, 250 ms calibrations.
// - Micro mode resumes only after new command.
// - Binary commands select each power mode.
// - Text protocol first; select command switches binary.
// - Qualified toggle edge flips hibernate and full-on.
// - Serial pins float during hibernate.
// - External reset low holds device reset.
module rpms_sequencer #(
   parameter WAKE_MIN_CYC = `RPMS_WAKE_MIN_CYC,
   parameter CYC_PER_MS = `RPMS_CYC_PER_MS
) (
   input wire core_clk,
   input wire reset_n,
   input wire ext_reset_low,
   input wire rtc_running,
   input wire power_toggle_in,
   output wire auto_wake_out,
   input wire port_strap_a,
   input wire port_strap_b,
   input wire [2:0] mode_sel,
   input wire mode_cmd_valid,
   input wire [7:0] pos_calc_mode,
   input wire [12:0] fix_period_s,
   input wire fix_valid,
   input wire weak_signal,
   input wire protocol_select_cmd,
   input wire [19:0] baud_cfg,
   input wire baud_cfg_valid,
   input wire sat_second,
   output reg full_on,
   output reg cold_start,
   output reg hot_start,
   output reg five_hz,
   output reg [1:0] port_type,
   output reg binary_protocol,
   output reg [19:0] baud_rate,
   output reg [3:0] char_format,
   output reg time_mark_pulse,
   output reg ok_to_send_msg,
   output reg serial_tx_oe,
   output wire [1:0] msg_kind,
   output wire msg_valid,
   input wire msg_ready
);
   localparam ST_RESET = 3'b001;
   localparam ST_HIB = 3'b010;
   localparam ST_ON = 3'b100;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [2:0] tog_sync_r;
   reg tog_level_r;
   reg [13:0] hi_cnt_r;
   reg tog_ok_r;
   reg woke_once_r;
   reg boot_done_r;
   reg [2:0] mode_r;
   reg mpm_hold_r;
   reg [27:0] ms_cnt_r;
   reg [12:0] sec_cnt_r;
   reg [15:0] on_ms_r;
   reg [15:0] on_len_r;
   reg [7:0] mark_ms_r;
   reg [16:0] mark_cyc_r;
   reg [2:0] sat_cnt_r;
   reg sched_busy_r;
   reg [1:0] sched_kind_r;
   reg [1:0] sched_left_r;
   reg [2:0] sec_sync_r;
   reg sec_level_r;
   wire in_reset;
   wire sec_edge;
   wire tog_rise;
   wire tog_fall;
   wire auto_wake;
   wire timed_sleep;
   wire fifo_ready;
   wire [12:0] pfm_period;

   // Clamp a requested period to the allowed wake range.
   function [12:0] clamp_period;
      input [12:0] req;
      begin
         if (req < `RPMS_PFM_MIN_S) begin
            clamp_period = 13'h000A;
         end else if (req > `RPMS_PFM_MAX_S) begin
            clamp_period = 13'h1C20;
         end else begin
            clamp_period = req;
         end
      end
   endfunction

   // Internal reset is held until the RTC runs, and the pin overrides it.
   assign in_reset = !reset_n || !ext_reset_low || !rtc_running;
   assign pfm_period = clamp_period(fix_period_s);

   // Three-stage sync; a level counts when stages two and three agree.
   always @(posedge core_clk) begin
      if (in_reset) begin
         tog_sync_r <= 3'h0;
         tog_level_r <= 1'b0;
         sec_sync_r <= 3'h0;
         sec_level_r <= 1'b0;
      end else begin
         tog_sync_r <= {tog_sync_r[1:0], power_toggle_in};
         sec_sync_r <= {sec_sync_r[1:0], sat_second};
         if (tog_sync_r[1] == tog_sync_r[2]) begin
            tog_level_r <= tog_sync_r[2];
         end
         if (sec_sync_r[1] == sec_sync_r[2]) begin
            sec_level_r <= sec_sync_r[2];
         end
      end
   end

   wire tog_now = (tog_sync_r[1] == tog_sync_r[2]) ? tog_sync_r[2] : tog_level_r;
   wire sec_now = (sec_sync_r[1] == sec_sync_r[2]) ? sec_sync_r[2] : sec_level_r;
   assign tog_rise = tog_now && !tog_level_r;
   assign tog_fall = !tog_now && tog_level_r;
   assign sec_edge = sec_now && !sec_level_r;

   // The toggle acts at the falling edge once the high was long enough, so
   // a glitch never flips the power state.
   always @(posedge core_clk) begin
      if (in_reset) begin
         hi_cnt_r <= 14'h0000;
         tog_ok_r <= 1'b0;
      end else begin
         tog_ok_r <= 1'b0;
         if (tog_rise) begin
            hi_cnt_r <= 14'h0000;
         end else if (tog_level_r && hi_cnt_r != 14'h3FFF) begin
            hi_cnt_r <= hi_cnt_r + 14'h0001;
         end
         if (tog_fall && hi_cnt_r >= WAKE_MIN_CYC[13:0]) begin
            tog_ok_r <= 1'b1;
         end
      end
   end

   // Auto wake pulse after boot; it drops once a looped high is long enough to count.
   assign auto_wake_out = boot_done_r && (state_r == ST_HIB) && !woke_once_r &&
      !(tog_level_r && hi_cnt_r >= WAKE_MIN_CYC[13:0]);

   // Millisecond and second ticks drive the duty timers.
   wire ms_tick = (ms_cnt_r == CYC_PER_MS - 1);
   always @(posedge core_clk) begin
      if (in_reset) begin
         ms_cnt_r <= 28'h0000000;
         sec_cnt_r <= 13'h0000;
         on_ms_r <= 16'h0000;
      end else begin
         ms_cnt_r <= ms_tick ? 28'h0000000 : ms_cnt_r + 28'h0000001;
         if (state_r != ST_HIB) begin
            sec_cnt_r <= 13'h0000;
         end else if (sec_edge) begin
            sec_cnt_r <= sec_cnt_r + 13'h0001;
         end
         if (state_r != ST_ON) begin
            on_ms_r <= 16'h0000;
         end else if (ms_tick && on_ms_r != 16'hFFFF) begin
            on_ms_r <= on_ms_r + 16'h0001;
         end
      end
   end

   // Timed wake from hibernate according to the selected duty mode.
   wire eph_due = (sec_cnt_r >= `RPMS_EPH_PERIOD_S - 1);
   assign auto_wake = sec_edge && (
      (mode_r == `RPMS_MODE_ADM && sec_cnt_r >= `RPMS_ADM_PERIOD_S - 1) ||
      (mode_r == `RPMS_MODE_PFM && sec_cnt_r >= pfm_period - 13'h0001) ||
      (mode_r == `RPMS_MODE_MPM && !mpm_hold_r && eph_due));
   // Timed return to hibernate once the on window is over.
   assign timed_sleep = (mode_r != `RPMS_MODE_FULL) && !mpm_hold_r &&
      (on_ms_r >= on_len_r) && !(mode_r == `RPMS_MODE_ADM && weak_signal);

   // Power state machine.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET: begin
            state_nxt = ST_HIB;
         end
         ST_HIB: begin
            if (tog_ok_r || auto_wake) begin
               state_nxt = ST_ON;
            end
         end
         ST_ON: begin
            if (tog_ok_r || timed_sleep) begin
               state_nxt = ST_HIB;
            end
         end
         default: begin
            state_nxt = ST_RESET;
         end
      endcase
   end

   // State, start kind, ready message and pin float control.
   always @(posedge core_clk) begin
      if (in_reset) begin
         state_r <= ST_RESET;
         boot_done_r <= 1'b0;
         woke_once_r <= 1'b0;
         full_on <= 1'b0;
         cold_start <= 1'b0;
         hot_start <= 1'b0;
         ok_to_send_msg <= 1'b0;
         serial_tx_oe <= 1'b0;
         on_len_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         boot_done_r <= 1'b1;
         cold_start <= 1'b0;
         hot_start <= 1'b0;
         ok_to_send_msg <= (state_r != state_nxt) && (state_r != ST_RESET);
         full_on <= (state_nxt == ST_ON);
         serial_tx_oe <= (state_nxt == ST_ON);
         if (state_r == ST_HIB && state_nxt == ST_ON) begin
            woke_once_r <= 1'b1;
            cold_start <= !woke_once_r;
            hot_start <= woke_once_r && tog_ok_r && mode_r == `RPMS_MODE_PFM;
            if (mode_r == `RPMS_MODE_MPM && !eph_due) begin
               on_len_r <= `RPMS_CAL_ON_MS;
            end else if (mode_r == `RPMS_MODE_MPM) begin
               on_len_r <= `RPMS_EPH_ON_MS;
            end else if (mode_r == `RPMS_MODE_ADM && eph_due) begin
               on_len_r <= 16'hFFFF;
            end else begin
               on_len_r <= `RPMS_ADM_ON_MS;
            end
         end
      end
   end

   // Mode commands; micro mode needs a fix and a host wake holds it off.
   always @(posedge core_clk) begin
      if (in_reset) begin
         mode_r <= `RPMS_MODE_FULL;
         mpm_hold_r <= 1'b0;
         five_hz <= 1'b0;
         binary_protocol <= 1'b0;
         baud_rate <= `RPMS_BAUD_DEF;
      end else begin
         if (mode_cmd_valid && binary_protocol) begin
            if (mode_sel != `RPMS_MODE_MPM || fix_valid) begin
               mode_r <= mode_sel;
               mpm_hold_r <= 1'b0;
            end
            five_hz <= pos_calc_mode[`RPMS_RATE_BIT];
         end
         if (tog_ok_r && state_r == ST_HIB && mode_r == `RPMS_MODE_MPM) begin
            mpm_hold_r <= 1'b1;
         end
         if (protocol_select_cmd) begin
            binary_protocol <= 1'b1;
         end
         if (baud_cfg_valid) begin
            baud_rate <= baud_cfg;
         end
      end
   end

   // Straps are caught once as reset releases; open straps mean SPI.
   always @(posedge core_clk) begin
      if (in_reset) begin
         port_type <= `RPMS_PORT_SPI;
         char_format <= 4'h8;
      end else if (!boot_done_r) begin
         if (port_strap_a && !port_strap_b) begin
            port_type <= `RPMS_PORT_UART;
         end else if (!port_strap_a && port_strap_b) begin
            port_type <= `RPMS_PORT_I2C;
         end else begin
            port_type <= `RPMS_PORT_SPI;
         end
      end
   end

   // Time mark: rises with the second, held for 200 ms.
   always @(posedge core_clk) begin
      if (in_reset) begin
         time_mark_pulse <= 1'b0;
         mark_ms_r <= 8'h00;
         mark_cyc_r <= 17'h00000;
      end else if (sec_edge && state_r == ST_ON) begin
         time_mark_pulse <= 1'b1;
         mark_ms_r <= 8'h00;
         mark_cyc_r <= 17'h00000;
      end else if (time_mark_pulse) begin
         if (mark_cyc_r == CYC_PER_MS - 1) begin
            mark_cyc_r <= 17'h00000;
            if (mark_ms_r == `RPMS_MARK_MS - 1) begin
               time_mark_pulse <= 1'b0;
            end
            mark_ms_r <= mark_ms_r + 8'h01;
         end else begin
            mark_cyc_r <= mark_cyc_r + 17'h00001;
         end
      end
   end

   // Per-second schedule; GSV group follows GSA every fifth second.
   always @(posedge core_clk) begin
      if (in_reset) begin
         sched_busy_r <= 1'b0;
         sched_kind_r <= `RPMS_MSG_FIX;
         sched_left_r <= 2'h0;
         sat_cnt_r <= 3'h0;
      end else if (sec_edge && state_r == ST_ON && !binary_protocol) begin
         sched_busy_r <= 1'b1;
         sched_kind_r <= `RPMS_MSG_FIX;
         sat_cnt_r <= (sat_cnt_r == `RPMS_SAT_PERIOD - 1) ? 3'h0 : sat_cnt_r + 3'h1;
         sched_left_r <= 2'h3;
      end else if (sched_busy_r && fifo_ready) begin
         case (sched_kind_r)
            `RPMS_MSG_FIX: begin
               sched_kind_r <= `RPMS_MSG_DOP;
            end
            `RPMS_MSG_DOP: begin
               sched_kind_r <= (sat_cnt_r == 3'h1) ? `RPMS_MSG_SAT : `RPMS_MSG_REC;
            end
            `RPMS_MSG_SAT: begin
               if (sched_left_r == 2'h0) begin
                  sched_kind_r <= `RPMS_MSG_REC;
               end
               sched_left_r <= sched_left_r - 2'h1;
            end
            default: begin
               sched_busy_r <= 1'b0;
            end
         endcase
      end
   end

   // Message queue toward the host port, stalls the schedule when full.
   rpms_fifo #(.WIDTH(2), .DEPTH(8), .AW(3)) u_fifo (
      .core_clk(core_clk),
      .reset_n(!in_reset),
      .in_data(sched_kind_r),
      .in_valid(sched_busy_r),
      .in_ready(fifo_ready),
      .out_data(msg_kind),
      .out_valid(msg_valid),
      .out_ready(msg_ready)
   );
endmodule

// File: rpms_seq_asserts.sv
`timescale 1ns/10ps
module rpms_seq_asserts #(
   parameter WAKE_MIN_CYC = 4,
   parameter CYC_PER_MS = 10
) (
   input wire core_clk,
   input wire reset_n,
   input wire ext_reset_low,
   input wire rtc_running,
   input wire power_toggle_in,
   input wire mode_cmd_valid,
   input wire [7:0] pos_calc_mode,
   input wire full_on,
   input wire cold_start,
   input wire hot_start,
   input wire five_hz,
   input wire [1:0] port_type,
   input wire binary_protocol,
   input wire [19:0] baud_rate,
   input wire [3:0] char_format,
   input wire time_mark_pulse,
   input wire ok_to_send_msg,
   input wire serial_tx_oe,
   input wire [1:0] msg_kind,
   input wire msg_valid,
   input wire msg_ready
);
   localparam int MARK_LEN = 200 * CYC_PER_MS;
   logic [15:0] mark_r;
   logic [7:0] low_r;
   logic [7:0] hi_r;
   // Any of the three reset sources holds the block.
   wire rst = !reset_n || !ext_reset_low || !rtc_running;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Run lengths of the mark pulse and of each toggle pin level; the two toggle counts saturate so they never wrap.
   always @(posedge core_clk) begin
      if (rst) begin
         mark_r <= 16'h0000;
         low_r <= 8'h00;
         hi_r <= 8'h00;
      end else begin
         mark_r <= time_mark_pulse ? mark_r + 16'h0001 : 16'h0000;
         low_r <= power_toggle_in ? 8'h00 : (low_r == 8'hFF ? low_r : low_r + 8'h01);
         hi_r <= !power_toggle_in ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + 8'h01);
      end
   end
   AST_OK_AT_CHANGE: assert property (!$past(rst) && $changed(full_on) |-> ok_to_send_msg)
      else $error("power state changed without ready message");
   AST_COLD_ON: assert property (cold_start |-> full_on)
      else $error("cold start while not full on");
   AST_HOT_ON: assert property (hot_start |-> full_on && !cold_start)
      else $error("hot start while not full on or with a cold start");
   AST_NO_SELF_WAKE: assert property (!binary_protocol && low_r > 8'd40 |-> !$rose(full_on))
      else $error("woke without a toggle pulse");
   AST_SHORT_IGNORED: assert property (!binary_protocol && $fell(power_toggle_in) && hi_r < 8'd2
      |-> $stable(full_on)[*8])
      else $error("short toggle changed power state");
   AST_PORT_HELD: assert property (!$past(rst, 1) && !$past(rst, 2) |-> $stable(port_type))
      else $error("port type changed while running");
   AST_CHAR_FMT: assert property (char_format == 4'h8)
      else $error("character format not eight bits");
   AST_BAUD_DEF: assert property ($past(rst) |-> baud_rate == 20'h012C0)
      else $error("baud rate not default after reset");
   AST_MARK_WIDTH: assert property (!$past(rst) && $fell(time_mark_pulse)
      |-> mark_r == MARK_LEN)
      else $error("time mark width wrong");
   AST_TX_FLOAT: assert property (!full_on && !$past(full_on) |-> !serial_tx_oe)
      else $error("serial pin driven in hibernate");
   AST_MSG_HOLD: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_kind))
      else $error("message dropped under back-pressure");
   AST_FIVE_HZ: assert property (mode_cmd_valid && binary_protocol && pos_calc_mode[2]
      |-> ##[1:4] five_hz)
      else $error("five per second rate not set");
endmodule
bind rpms_sequencer rpms_seq_asserts #(.WAKE_MIN_CYC(WAKE_MIN_CYC), .CYC_PER_MS(CYC_PER_MS)) chk_u (
   .core_clk(core_clk), .reset_n(reset_n), .ext_reset_low(ext_reset_low),
   .rtc_running(rtc_running), .power_toggle_in(power_toggle_in), .mode_cmd_valid(mode_cmd_valid),
   .pos_calc_mode(pos_calc_mode), .full_on(full_on), .cold_start(cold_start), .five_hz(five_hz),
   .hot_start(hot_start),
   .port_type(port_type), .binary_protocol(binary_protocol), .baud_rate(baud_rate),
   .char_format(char_format), .time_mark_pulse(time_mark_pulse),
   .ok_to_send_msg(ok_to_send_msg), .serial_tx_oe(serial_tx_oe), .msg_kind(msg_kind),
   .msg_valid(msg_valid), .msg_ready(msg_ready));

// File: rpms_host_model.sv
`timescale 1ns/10ps
// Host side: pulses the wake toggle pin and drains the message stream with stalls.
module rpms_host_model (
   input wire core_clk,
   input wire msg_valid,
   input wire [1:0] msg_kind,
   output logic power_toggle_in = 1'b0,
   output logic msg_ready = 1'b0
);
   logic [1:0] got_q[$];
   logic [1:0] stall_r = 2'h0;
   // Ready drops one cycle in four so the FIFO sees back-pressure every fourth cycle.
   always @(negedge core_clk) begin
      stall_r <= stall_r + 2'h1;
      msg_ready <= (stall_r != 2'h3);
   end
   // Every accepted message kind is logged for the bench.
   always @(posedge core_clk) begin
      if (msg_valid === 1'b1 && msg_ready) got_q.push_back(msg_kind);
   end
   // Low, high for hi cycles, low again; the tail lets the device settle before the next request.
   task wake(input int hi);
      @(negedge core_clk) power_toggle_in = 1'b1;
      repeat (hi) @(negedge core_clk);
      power_toggle_in = 1'b0;
      repeat (20) @(negedge core_clk);
   endtask
endmodule

// File: rpms_tb.sv
`timescale 1ns/10ps
`include "rpms_map.vh"
module tb;
   localparam int WK = 4;
   localparam int MS = 10;
   localparam int SEC = 1000 * MS;
   logic core_clk = 0, reset_n = 0, ext_reset_low = 1, rtc_running = 1;
   logic strap_a = 0, strap_b = 0, mode_cmd_valid = 0, fix_valid = 0, weak_signal = 0;
   logic protocol_select_cmd = 0, baud_cfg_valid = 0, sat_second = 0;
   logic [2:0] mode_sel = 3'h0;
   logic [7:0] pos_calc_mode = 8'h00;
   logic [12:0] fix_period_s = 13'h0708;
   logic [19:0] baud_cfg = 20'h00000;
   wire power_toggle_in, auto_wake_out, full_on, cold_start, hot_start, five_hz, binary_protocol;
   wire time_mark_pulse, ok_to_send_msg, serial_tx_oe, msg_valid, msg_ready;
   wire [1:0] port_type, msg_kind;
   wire [19:0] baud_rate;
   wire [3:0] char_format;
   int bad_count = 0, n_tests = 0, cyc = 0, cold_n = 0, ok_n = 0, hot_n = 0;

   rpms_sequencer #(.WAKE_MIN_CYC(WK), .CYC_PER_MS(MS)) dut_u (.core_clk(core_clk),
      .reset_n(reset_n), .ext_reset_low(ext_reset_low), .rtc_running(rtc_running),
      .power_toggle_in(power_toggle_in), .auto_wake_out(auto_wake_out), .port_strap_a(strap_a),
      .port_strap_b(strap_b), .mode_sel(mode_sel), .mode_cmd_valid(mode_cmd_valid),
      .pos_calc_mode(pos_calc_mode), .fix_period_s(fix_period_s), .fix_valid(fix_valid),
      .weak_signal(weak_signal), .protocol_select_cmd(protocol_select_cmd), .baud_cfg(baud_cfg),
      .baud_cfg_valid(baud_cfg_valid), .sat_second(sat_second), .full_on(full_on),
      .cold_start(cold_start), .hot_start(hot_start), .five_hz(five_hz), .port_type(port_type),
      .binary_protocol(binary_protocol), .baud_rate(baud_rate), .char_format(char_format),
      .time_mark_pulse(time_mark_pulse), .ok_to_send_msg(ok_to_send_msg),
      .serial_tx_oe(serial_tx_oe), .msg_kind(msg_kind), .msg_valid(msg_valid),
      .msg_ready(msg_ready));
   rpms_host_model host_u (.core_clk(core_clk), .msg_valid(msg_valid), .msg_kind(msg_kind),
      .power_toggle_in(power_toggle_in), .msg_ready(msg_ready));

   always #4 core_clk = ~core_clk;
   // Satellite second edge once per scaled second.
   always @(negedge core_clk) sat_second <= (cyc % SEC) < 10;
   // One-cycle pulses are counted here; the cycle ceiling cuts a hang short.
   always @(posedge core_clk) begin
      cyc++;
      if (cold_start === 1'b1) cold_n++;
      if (hot_start === 1'b1) hot_n++;
      if (ok_to_send_msg === 1'b1) ok_n++;
      if (cyc == 90000) begin
         bad_count++;
         summarize();
      end
   end

   task summarize();
      if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wait_full(input logic v, input int n);
      for (int i = 0; i < n && full_on !== v; i++) @(negedge core_clk);
   endtask
   task send_mode(input logic [2:0] m);
      mode_sel = m;
      mode_cmd_valid = 1;
      @(negedge core_clk) mode_cmd_valid = 0;
   endtask
   task do_reset();
      @(negedge core_clk) reset_n = 0;
      repeat (6) @(negedge core_clk);
      reset_n = 1;
      repeat (3) @(negedge core_clk);
   endtask
   // Boot values: hibernate, text protocol, factory serial settings.
   task t_defaults();
      chk(full_on, 0);
      chk(baud_rate, 20'h012C0);
      chk(char_format, 4'h8);
      chk(port_type, `RPMS_PORT_SPI);
      chk(binary_protocol, 0);
      chk(auto_wake_out, 1);
   endtask
   // A one-cycle high must not count as a wake request.
   task t_short();
      host_u.wake(1);
      chk(full_on, 0);
   endtask
   // A qualified toggle flips the power state with one ready message; the first wake after boot is a cold start.
   task t_wake(input logic v, input int c);
      int o;
      o = ok_n;
      host_u.wake(WK + 4);
      wait_full(v, 100);
      chk(full_on, v);
      chk(auto_wake_out, 0);
      chk(cold_n, c);
      chk(ok_n - o, 1);
      if (!v) chk(serial_tx_oe, 0);
   endtask
   // Five seconds of traffic with stalls; every step must follow the default order.
   task t_schedule();
      int bad, sats;
      logic go;
      logic [1:0] p, k;
      bad = 0;
      sats = 0;
      go = 0;
      host_u.got_q.delete();
      repeat (5 * SEC + 500) @(negedge core_clk);
      foreach (host_u.got_q[i]) begin
         k = host_u.got_q[i];
         if (go) begin
            case (p)
               `RPMS_MSG_FIX: bad += (k != `RPMS_MSG_DOP);
               `RPMS_MSG_REC: bad += (k != `RPMS_MSG_FIX);
               default: bad += (k != `RPMS_MSG_SAT && k != `RPMS_MSG_REC);
            endcase
         end
         go = go || (k == `RPMS_MSG_FIX);
         sats += (k == `RPMS_MSG_SAT);
         p = k;
      end
      chk(bad, 0);
      chk(sats, 4);
      chk(host_u.got_q.size() >= 12, 1);
      chk(time_mark_pulse, 1);
   endtask
   // Adaptive duty wakes on the second and sleeps after its on window; a micro mode
   // request without a fix is refused, and a host pulse in periodic fix mode is a hot start.
   task t_duty();
      send_mode(`RPMS_MODE_ADM);
      wait_full(1, 12 * SEC / 10);
      chk(full_on, 1);
      repeat (490 * MS) @(negedge core_clk);
      chk(full_on, 1);
      repeat (20 * MS) @(negedge core_clk);
      chk(full_on, 0);
      send_mode(`RPMS_MODE_MPM);
      wait_full(1, 12 * SEC / 10);
      chk(full_on, 1);
      send_mode(`RPMS_MODE_PFM);
      wait_full(0, 600 * MS);
      chk(full_on, 0);
      host_u.wake(WK + 4);
      chk(full_on, 1);
      chk(hot_n, 1);
   endtask
   // Baud change, protocol switch, then the fix-rate bit both ways.
   task t_config();
      @(negedge core_clk) baud_cfg = 20'h09600;
      baud_cfg_valid = 1;
      @(negedge core_clk) baud_cfg_valid = 0;
      repeat (3) @(negedge core_clk);
      chk(baud_rate, 20'h09600);
      protocol_select_cmd = 1;
      @(negedge core_clk) protocol_select_cmd = 0;
      repeat (3) @(negedge core_clk);
      chk(binary_protocol, 1);
      for (int i = 0; i < 2; i++) begin
         pos_calc_mode = (i == 0) ? 8'h04 : 8'hFB;
         mode_cmd_valid = 1;
         @(negedge core_clk) mode_cmd_valid = 0;
         repeat (5) @(negedge core_clk);
         chk(five_hz, i == 0);
      end
   endtask
   // The external reset pin restores factory settings.
   task t_ext_reset();
      ext_reset_low = 0;
      repeat (2) @(negedge core_clk);
      ext_reset_low = 1;
      repeat (3) @(negedge core_clk);
      chk(baud_rate, 20'h012C0);
      chk(binary_protocol, 0);
      chk(five_hz, 0);
   endtask
   // Straps are taken at reset only; moving them afterwards changes nothing.
   task t_straps();
      logic [1:0] exp [3] = '{`RPMS_PORT_UART, `RPMS_PORT_I2C, `RPMS_PORT_SPI};
      for (int i = 0; i < 3; i++) begin
         strap_a = (i != 1);
         strap_b = (i != 0);
         do_reset();
         chk(port_type, exp[i]);
         strap_a = !strap_a;
         repeat (5) @(negedge core_clk);
         chk(port_type, exp[i]);
      end
   endtask

   initial begin
      repeat (6) @(negedge core_clk);
      reset_n = 1;
      repeat (3) @(negedge core_clk);
      t_defaults();
      t_short();
      t_wake(1, 1);
      t_schedule();
      t_wake(0, 1);
      t_config();
      t_duty();
      t_ext_reset();
      t_straps();
      summarize();
   end
endmodule
